// File: verilog/sto_params.svh
`ifndef STO_PARAMS_SVH
`define STO_PARAMS_SVH
// Clock period in picoseconds (125 MHz)
`define STO_CLK_PERIOD_PS 8000
// Gate-off response time (ms): typical and maximum
`define STO_RESP_TYP_MS 1140
`define STO_RESP_MAX_MS 2140
// Gate-off delay in cycles, typical time rounds down
`define STO_GATE_OFF_CYC ((`STO_RESP_TYP_MS * 64'd1000000000) / `STO_CLK_PERIOD_PS)
// Emergency message code
`define STO_EMCY_CODE 16'hff80
`endif

// File: verilog/sto_pkg.sv
package sto_pkg;
  // Drive state
  typedef enum logic [1:0] {
    STO_RUN,
    STO_STOP,
    STO_ARMED
  } sto_state_t;
endpackage

// File: verilog/sto_sync.sv
`timescale 1ns/1ps
module sto_sync (
  input wire logic core_clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic d, // Asynchronous level
  output logic q // Synchronised level
);
  logic s1_r;
  logic s2_r;
  logic s1_nxt;
  logic s2_nxt;
  ////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; first stage feeds only the second
  always_comb
  begin
    s1_nxt = d;
    s2_nxt = s1_r;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end
  assign q = s2_r;
endmodule

// File: verilog/sto_delay.sv
`timescale 1ns/1ps
module sto_delay #(
  parameter int unsigned CNT = 32'd142500000 // Cycles until expiry
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic run, // Count while high, clear when low
  output logic done // High once CNT cycles elapsed
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic done_r;
  logic done_nxt;
  ////////////////////////////////////////////////////////////////
  // Saturating counter; done is registered
  always_comb
  begin
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    if (!run)
    begin
      cnt_nxt = 32'h0;
      done_nxt = 1'b0;
    end
    else if (cnt_r >= CNT - 32'd1)
      done_nxt = 1'b1;
    else
      cnt_nxt = cnt_r + 32'h1;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_r <= 32'h0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end
  assign done = done_r;
endmodule

// File: verilog/sto_latch.sv
// Behaviour
// - Losing the safety input enters safe stop and blocks the inverter.
// - Leaving safe stop needs input restored, then a CAN reset and restart.
// - Gate drivers off no later than 2.14 s after loss, typically 1.14 s.
// - Entering safe stop sends emergency code FF80; motor coasts.
// - Entering safe stop engages the brake when one is fitted.
// - Reset and restart with input still lost keep safe stop and brake.
// - A CAN reset while input is lost resends the emergency message.
// - Restoring input alone keeps coasting and brake until reset and restart.
// - After restore, reset then restart returns to normal operation.
// - Safe stop depends only on this drive's own safety input.
`timescale 1ns/1ps
`include "sto_params.svh"
module sto_latch #(
  parameter int unsigned GATE_OFF_CYC = 32'(`STO_GATE_OFF_CYC) // Loss-to-gate-off cycles
) (
  input wire logic core_clk, // 125 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic safety_in, // Safety input level, high = 24 V present
  input wire logic brake_fitted, // High when a brake is installed
  input wire logic can_reset, // One-cycle pulse: CAN reset received
  input wire logic can_restart, // One-cycle pulse: CAN restart received
  input wire logic motion_req, // Motion controller wants gates enabled
  output logic gate_en, // Inverter gate driver enable
  output logic brake_release, // High releases the brake
  output logic emcy_req, // One-cycle pulse: send emergency message
  output logic [15:0] emcy_code, // Code carried with emcy_req
  output logic safe_stop // High while in safe stop
);
  import sto_pkg::*;

  logic safe_ok;
  logic gate_timeout;
  sto_state_t state_r;
  sto_state_t state_nxt;
  logic gate_en_r;
  logic gate_en_nxt;
  logic brake_rel_r;
  logic brake_rel_nxt;
  logic emcy_r;
  logic emcy_nxt;
  logic [15:0] code_r;
  logic [15:0] code_nxt;
  logic stop_r;
  logic stop_nxt;

  ////////////////////////////////////////////////////////////////
  // Only this drive's own input is watched
  sto_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(safety_in),
    .q(safe_ok)
  );

  // Backstop timer: gates are cut immediately on loss, this only guards
  // against the gate path staying on past the response budget
  sto_delay #(
    .CNT(GATE_OFF_CYC)
  ) u_delay (
    .core_clk(core_clk),
    .rst(rst),
    .run(!safe_ok && gate_en_r),
    .done(gate_timeout)
  );

  ////////////////////////////////////////////////////////////////
  // Latch state: reset comes up in safe stop so power-up never self-starts
  always_comb
  begin
    state_nxt = state_r;
    emcy_nxt = 1'b0;
    code_nxt = code_r;
    case (state_r)
      STO_RUN:
      begin
        if (!safe_ok)
        begin
          state_nxt = STO_STOP;
          emcy_nxt = 1'b1;
          code_nxt = `STO_EMCY_CODE;
        end
      end
      STO_STOP:
      begin
        if (can_reset && !safe_ok)
        begin
          emcy_nxt = 1'b1;
          code_nxt = `STO_EMCY_CODE;
        end
        else if (can_reset && safe_ok)
          state_nxt = STO_ARMED;
        // Restart without reset, or with input lost, is ignored
      end
      STO_ARMED:
      begin
        if (!safe_ok)
        begin
          state_nxt = STO_STOP;
          emcy_nxt = 1'b1;
          code_nxt = `STO_EMCY_CODE;
        end
        else if (can_restart)
          state_nxt = STO_RUN;
      end
      default:
        state_nxt = STO_STOP;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Outputs: gates and brake follow the next state so loss acts in one cycle
  always_comb
  begin
    stop_nxt = (state_nxt != STO_RUN);
    // Motor coasts: gates off, no braking torque from the inverter
    gate_en_nxt = (state_nxt == STO_RUN) && safe_ok && motion_req && !gate_timeout;
    // Brake engaged whenever stopped; a missing brake ignores the line
    brake_rel_nxt = !((state_nxt != STO_RUN) && brake_fitted);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= STO_STOP;
      gate_en_r <= 1'b0;
      brake_rel_r <= 1'b0;
      emcy_r <= 1'b0;
      code_r <= 16'h0000;
      stop_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      gate_en_r <= gate_en_nxt;
      brake_rel_r <= brake_rel_nxt;
      emcy_r <= emcy_nxt;
      code_r <= code_nxt;
      stop_r <= stop_nxt;
    end
  end

  assign gate_en = gate_en_r;
  assign brake_release = brake_rel_r;
  assign emcy_req = emcy_r;
  assign emcy_code = code_r;
  assign safe_stop = stop_r;
endmodule

// File: dv/sto_master_model.sv
`timescale 1ns/1ps
module sto_master_model (
  input wire logic core_clk, // Clock
  output logic safety_in, // Safety contact, high = 24 V
  output logic can_reset, // CAN reset pulse
  output logic can_restart // CAN restart pulse
);
  initial
  begin
    safety_in = 1'b1;
    can_reset = 1'b0;
    can_restart = 1'b0;
  end
  // Contact opens only for a hazard; routine stops go through motion_req
  task automatic trip(input logic v);
    @(posedge core_clk);
    safety_in <= v;
  endtask
  // One command per cycle; recovery is reset first, then restart
  task automatic step(input logic r, input logic s);
    @(posedge core_clk);
    can_reset <= r;
    can_restart <= s;
  endtask
endmodule

// File: dv/sto_latch_assertions.sv
`timescale 1ns/1ps
module sto_latch_chk #(
  parameter int unsigned GATE_OFF_CYC = 32'd20 // Backstop count
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic safety_in, // Safety level
  input wire logic brake_fitted, // Brake present
  input wire logic can_reset, // Reset pulse
  input wire logic can_restart, // Restart pulse
  input wire logic motion_req, // Motion wanted
  input wire logic gate_en, // Gates on
  input wire logic brake_release, // Brake free
  input wire logic emcy_req, // Message pulse
  input wire logic [15:0] emcy_code, // Message code
  input wire logic safe_stop // Stopped
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Two sync flops plus the output flop give three cycles from loss to outputs
  property p_off; $fell(safety_in) |-> ##3 !gate_en && safe_stop; endproperty
  a_off: assert property (p_off) else $error("gates on");
  property p_brk; $fell(safety_in) && brake_fitted |-> ##3 !brake_release; endproperty
  a_brk: assert property (p_brk) else $error("brake free");
  property p_msg; $fell(safety_in) && !safe_stop |-> ##3 emcy_req && emcy_code == 16'hff80;
  endproperty
  a_msg: assert property (p_msg) else $error("no message");
  property p_gate; gate_en |-> !safe_stop; endproperty
  a_gate: assert property (p_gate) else $error("gates in stop");
  property p_stay; safe_stop && !$past(safety_in, 2) |=> safe_stop && !(brake_fitted &&
    brake_release); endproperty
  a_stay: assert property (p_stay) else $error("left stop");
  property p_again; safe_stop && can_reset && !$past(safety_in, 2) |=> emcy_req; endproperty
  a_again: assert property (p_again) else $error("no resend");
  property p_hold; safe_stop && !can_restart |=> safe_stop; endproperty
  a_hold: assert property (p_hold) else $error("resumed");
  property p_arm; safe_stop && can_reset && $past(safety_in, 2) && $past(safety_in) ##1
    can_restart |=> !safe_stop && brake_release && gate_en == $past(motion_req); endproperty
  a_arm: assert property (p_arm) else $error("no restart");
  c_msg: cover property (emcy_req);
  c_run: cover property ($fell(safe_stop));
  c_lost: cover property (safe_stop && can_reset && !safety_in);
endmodule
bind sto_latch sto_latch_chk #(.GATE_OFF_CYC(GATE_OFF_CYC)) i_chk (.core_clk, .rst, .safety_in,
  .brake_fitted, .can_reset, .can_restart, .motion_req, .gate_en, .brake_release, .emcy_req,
  .emcy_code, .safe_stop);

// File: dv/sto_latch_tb.sv
`timescale 1ns/1ps
`include "sto_params.svh"
module sto_latch_tb;
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
  logic core_clk, rst, brake_fitted, motion_req, safety_in, can_reset, can_restart;
  logic gate_en, brake_release, emcy_req, safe_stop;
  logic [15:0] emcy_code;
  int miscompares = 0, checks = 0, cyc = 0;
  // Short backstop keeps the run brief
  sto_latch #(.GATE_OFF_CYC(20)) i_sto_latch (.core_clk, .rst, .safety_in, .brake_fitted,
    .can_reset, .can_restart, .motion_req, .gate_en, .brake_release, .emcy_req, .emcy_code,
    .safe_stop);
  sto_master_model i_sto_master_model (.core_clk, .safety_in, .can_reset, .can_restart);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      complete_run;
    end
  end
  task automatic t_trip;
    i_sto_master_model.trip(1'b0);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("gate", 1'b0, gate_en)
    `CHK("brake", !brake_fitted, brake_release)
    `CHK("emcy", 1'b1, emcy_req)
    `CHK("code", `STO_EMCY_CODE, emcy_code)
    $display("trip done");
  endtask
  // Reset and restart while the contact is still open
  task automatic t_lost;
    i_sto_master_model.step(1'b1, 1'b0);
    i_sto_master_model.step(1'b0, 1'b1);
    #1;
    `CHK("resend", 1'b1, emcy_req)
    i_sto_master_model.step(1'b0, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("stop", 1'b1, safe_stop)
    `CHK("held", !brake_fitted, brake_release)
    $display("lost done");
  endtask
  task automatic t_restore;
    i_sto_master_model.trip(1'b1);
    repeat (10) @(posedge core_clk);
    #1;
    `CHK("coast", 1'b0, gate_en)
    `CHK("latched", 1'b1, safe_stop)
    i_sto_master_model.step(1'b1, 1'b0);
    i_sto_master_model.step(1'b0, 1'b1);
    i_sto_master_model.step(1'b0, 1'b0);
    #1;
    `CHK("run", 1'b0, safe_stop)
    `CHK("drive", 1'b1, gate_en)
    `CHK("free", 1'b1, brake_release)
    $display("restore done");
  endtask
  // Routine stop through motion_req leaves the latch alone; gates follow it
  task automatic t_motion;
    @(posedge core_clk) motion_req <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("idle_gate", 1'b0, gate_en)
    `CHK("idle_run", 1'b0, safe_stop)
    @(posedge core_clk) motion_req <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK("move_gate", 1'b1, gate_en)
    $display("motion done");
  endtask
  initial
  begin
    rst = 1'b1;
    brake_fitted = 1'b1;
    motion_req = 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK("boot", 1'b1, safe_stop)
    t_restore;
    t_trip;
    t_lost;
    t_restore;
    @(posedge core_clk) brake_fitted <= 1'b0;
    t_trip;
    t_lost;
    t_restore;
    t_motion;
    complete_run;
  end
endmodule
